// file: hw/sync_serial_port.sv
// spi mode of the synchronous serial port with an axi4-lite register slave
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timerTick,
  input  wire logic        sckIn,
  output var  logic        sckOut,
  output var  logic        sckOe_n,
  input  wire logic        sdi,
  output var  logic        sdo,
  output var  logic        sdoOe_n,
  input  wire logic        selectIn_n,
  output var  logic        pinsOwned,
  output var  logic        transferDone
);
  typedef enum logic [1:0] {IDLE, LEAD, TRAIL} phase_e;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] statusHigh;
  logic       stopFlag;
  logic       bufFull;
  logic [7:0] control;
  logic [7:0] dataBuf;
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic       busy;
  phase_e     phase;
  logic [4:0] divCnt;
  logic       timerHalf;
  logic       sampleHold;
  logic       sampleLate;
  logic       sdiBit;

  // synchronisers, first stage read only by the second
  logic [1:0] sckSync, selSync, sdiSync, tickSync;
  logic       sckPrev, tickPrev;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [3:0] mode     = control[3:0];
  wire       enable   = control[sync_serial_pkg::CT_EN];
  wire       pol      = control[sync_serial_pkg::CT_POL];
  wire       edgeSel  = statusHigh[sync_serial_pkg::ST_EDGE - 6];
  wire       smpEnd   = statusHigh[sync_serial_pkg::ST_SAMPLE - 6];
  wire       isMaster = enable && (mode <= sync_serial_pkg::MODE_TIMER);
  wire       isSlave  = enable && (mode == sync_serial_pkg::MODE_SLV_SS ||
                                   mode == sync_serial_pkg::MODE_SLV);
  wire       selUsed  = mode == sync_serial_pkg::MODE_SLV_SS;
  wire       slvReset = isSlave && selUsed && selSync[1];
  wire       slvAct   = isSlave && !slvReset;

  // axi handshakes: write taken when address and data both present
  wire wrGo  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire rdGo  = s_axi_arvalid && !s_axi_rvalid;
  wire wrSt  = wrGo && s_axi_awaddr == sync_serial_pkg::OFS_STATUS  && s_axi_wstrb[0];
  wire wrCt  = wrGo && s_axi_awaddr == sync_serial_pkg::OFS_CONTROL && s_axi_wstrb[0];
  wire wrDat = wrGo && s_axi_awaddr == sync_serial_pkg::OFS_DATA    && s_axi_wstrb[0];
  wire rdDat = rdGo && s_axi_araddr == sync_serial_pkg::OFS_DATA;
  wire wrBad = wrGo && s_axi_awaddr != sync_serial_pkg::OFS_STATUS &&
               s_axi_awaddr != sync_serial_pkg::OFS_CONTROL &&
               s_axi_awaddr != sync_serial_pkg::OFS_DATA;
  wire rdBad = rdGo && s_axi_araddr != sync_serial_pkg::OFS_STATUS &&
               s_axi_araddr != sync_serial_pkg::OFS_CONTROL &&
               s_axi_araddr != sync_serial_pkg::OFS_DATA;

  // a write while shifting is a collision; a slave with an idle counter
  // that has seen no edge may still be loaded
  wire inFlight = isMaster ? busy : (slvAct && bitCnt != 4'h0);
  wire collide  = wrDat && (inFlight || !(isMaster || isSlave));
  wire loadOk   = wrDat && !collide;
  wire startTx  = loadOk && isMaster;

  // master bit timing
  wire [4:0] halfCnt = (mode == sync_serial_pkg::MODE_DIV4)  ? sync_serial_pkg::HALF_DIV4  :
                       (mode == sync_serial_pkg::MODE_DIV16) ? sync_serial_pkg::HALF_DIV16 :
                       sync_serial_pkg::HALF_DIV64;
  wire tickRise = tickSync[1] && !tickPrev;
  wire useTimer = mode == sync_serial_pkg::MODE_TIMER;
  wire halfTick = busy && (useTimer ? tickRise : (divCnt == 5'h00));
  // middle sampling happens on the leading-to-trailing half edge
  wire mSample  = halfTick && (phase == LEAD);
  wire mShift   = halfTick && (phase == TRAIL);
  wire mLast    = mShift && bitCnt == 4'(sync_serial_pkg::BITS - 1);
  // middle sampling waits two clocks to cover the data-in synchroniser;
  // at the fastest rate that point coincides with the shift
  wire mCatch   = smpEnd ? mShift : sampleLate;
  wire mBit     = mCatch ? sdiSync[1] : sdiBit;

  // slave edges: leading edge leaves idle level
  wire sckRise  = sckSync[1] && !sckPrev;
  wire sckFall  = !sckSync[1] && sckPrev;
  wire leadEdge = slvAct && (pol ? sckFall : sckRise);
  wire trailEdge = slvAct && (pol ? sckRise : sckFall);
  // edge select 1: sampled on leading, data out changes on that same leading edge
  wire sSample  = edgeSel ? leadEdge : trailEdge;
  wire sShift   = edgeSel ? trailEdge : leadEdge;
  wire sLastIn  = sSample && bitCnt == 4'(sync_serial_pkg::BITS - 1);

  wire [7:0] inWord = {shiftReg[6:0], isMaster ? mBit : sdiSync[1]};
  wire       done   = (isMaster && mLast) || (isSlave && sLastIn);
  wire       ovf    = isSlave && sLastIn && bufFull && !rdDat;

  wire [7:0] statusView = {statusHigh, 1'b0, stopFlag, 3'b000, bufFull};
  wire [7:0] rdByte = (s_axi_araddr == sync_serial_pkg::OFS_STATUS)  ? statusView :
                      (s_axi_araddr == sync_serial_pkg::OFS_CONTROL) ? control : dataBuf;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sckSync  <= 2'h0;
      selSync  <= 2'h3;
      sdiSync  <= 2'h0;
      tickSync <= 2'h0;
      sckPrev  <= 1'b0;
      tickPrev <= 1'b0;
    end else begin
      sckSync  <= {sckSync[0], sckIn};
      selSync  <= {selSync[0], selectIn_n};
      sdiSync  <= {sdiSync[0], sdi};
      tickSync <= {tickSync[0], timerTick};
      sckPrev  <= sckSync[1];
      tickPrev <= tickSync[1];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= sync_serial_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= sync_serial_pkg::RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      s_axi_awready <= wrGo;
      s_axi_wready  <= wrGo;
      s_axi_arready <= rdGo;
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrBad ? sync_serial_pkg::RESP_SLVERR : sync_serial_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rdBad ? sync_serial_pkg::RESP_SLVERR : sync_serial_pkg::RESP_OKAY;
        s_axi_rdata  <= rdBad ? 32'h0000_0000 : {24'h00_0000, rdByte};
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      control    <= sync_serial_pkg::CONTROL_RST;
      statusHigh <= sync_serial_pkg::STATUS_RST[7:6];
      stopFlag   <= sync_serial_pkg::STATUS_RST[sync_serial_pkg::ST_STOP];
      bufFull    <= sync_serial_pkg::STATUS_RST[0];
    end else begin
      if (wrSt)
        statusHigh <= s_axi_wdata[7:6];
      if (wrCt)
        control <= s_axi_wdata[7:0];
      // hardware sets win over software clears
      if (collide)
        control[sync_serial_pkg::CT_WRITE_COLLISION_FLAG] <= 1'b1;
      if (ovf)
        control[sync_serial_pkg::CT_OVF] <= 1'b1;
      if (!enable)
        stopFlag <= 1'b0;
      if (done && !(ovf))
        bufFull <= 1'b1;
      else if (rdDat)
        bufFull <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dataBuf    <= 8'h00;
      shiftReg   <= 8'h00;
      bitCnt     <= 4'h0;
      busy       <= 1'b0;
      phase      <= IDLE;
      divCnt     <= 5'h00;
      sdiBit     <= 1'b0;
      sampleHold <= 1'b0;
      sampleLate <= 1'b0;
    end else begin
      // a deselected slave must still accept its next word to send
      if (loadOk) begin
        dataBuf    <= s_axi_wdata[7:0];
        shiftReg   <= s_axi_wdata[7:0];
        busy       <= isMaster;
        phase      <= isMaster ? LEAD : IDLE;
        divCnt     <= halfCnt;
        bitCnt     <= 4'h0;
        sampleHold <= 1'b0;
        sampleLate <= 1'b0;
      end else if (!enable || slvReset) begin
        bitCnt <= 4'h0;
        busy   <= 1'b0;
        phase  <= IDLE;
      end else if (isMaster && busy) begin
        divCnt     <= (divCnt == 5'h00) ? halfCnt : divCnt - 5'h01;
        sampleHold <= mSample;
        sampleLate <= sampleHold;
        if (mCatch)
          sdiBit <= sdiSync[1];
        if (halfTick)
          phase <= (phase == LEAD) ? TRAIL : LEAD;
        if (mShift) begin
          shiftReg <= inWord;
          bitCnt   <= bitCnt + 4'h1;
          if (mLast) begin
            busy    <= 1'b0;
            phase   <= IDLE;
            dataBuf <= inWord;
            bitCnt  <= 4'h0;
          end
        end
      end else if (slvAct) begin
        if (sSample) begin
          shiftReg <= inWord;
          bitCnt   <= sLastIn ? 4'h0 : bitCnt + 4'h1;
          if (sLastIn && !ovf)
            dataBuf <= inWord;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // with edge select 0 the first bit must stand before the first edge,
  // so sdo is registered from the msb of the shift register on every clock
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sckOut       <= 1'b0;
      sckOe_n      <= 1'b1;
      sdo          <= 1'b0;
      sdoOe_n      <= 1'b1;
      pinsOwned    <= 1'b0;
      transferDone <= 1'b0;
    end else begin
      pinsOwned    <= isMaster || isSlave;
      sckOe_n      <= !isMaster;
      sckOut       <= (busy && phase == TRAIL) ? !pol : pol;
      sdo          <= shiftReg[7];
      sdoOe_n      <= !(isMaster || slvAct);
      transferDone <= done && !ovf;
    end
  end
endmodule // sync_serial_port
`default_nettype wire

// file: hw/sync_serial_pkg.sv
// constants, register map and mode codes of the synchronous serial port
package sync_serial_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_STATUS  = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_DATA    = 4'h8;
  localparam logic [7:0] STATUS_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ST_SAMPLE = 7;
  localparam int ST_EDGE   = 6;
  localparam int ST_STOP   = 4;
  localparam int ST_FULL   = 0;
  localparam int CT_WRITE_COLLISION_FLAG   = 7;
  localparam int CT_OVF    = 6;
  localparam int CT_EN     = 5;
  localparam int CT_POL    = 4;
  // ----------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_DIV4   = 4'h0;
  localparam logic [3:0] MODE_DIV16  = 4'h1;
  localparam logic [3:0] MODE_DIV64  = 4'h2;
  localparam logic [3:0] MODE_TIMER  = 4'h3;
  localparam logic [3:0] MODE_SLV_SS = 4'h4;
  localparam logic [3:0] MODE_SLV    = 4'h5;
  // half periods of the serial clock in system clocks, minus one (fosc/4 -> 2, stored as 1)
  localparam logic [4:0] HALF_DIV4  = 5'h01;
  localparam logic [4:0] HALF_DIV16 = 5'h07;
  localparam logic [4:0] HALF_DIV64 = 5'h1F;
  localparam int         BITS       = 8;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: dv/sync_serial_port_chk.sv
// concurrent checks on the serial port top-level ports
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_chk (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sckOut,
  input wire logic        sckOe_n,
  input wire logic        sdoOe_n,
  input wire logic        pinsOwned,
  input wire logic        transferDone
);
  // ------------------------------------------------------------------
  // bus answers, pin ownership and serial clock
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence wrReq; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
  sequence wrAns; s_axi_awready && s_axi_wready && s_axi_bvalid; endsequence
  sequence badRd; s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > 4'h8; endsequence
  // one system clock per half period would let a flipped divider slip through
  sequence sckMove; $changed(sckOut) && !sckOe_n && !$past(sckOe_n); endsequence
  chk_wr_answer: assert property (wrReq |=> wrAns)
    else $error("write request not answered");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  chk_unmapped_read: assert property (badRd |=> s_axi_rresp == sync_serial_pkg::RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  chk_done_pulse: assert property (transferDone |=> !transferDone)
    else $error("done pulse too long");
  chk_sck_owned: assert property (!sckOe_n |-> pinsOwned)
    else $error("clock driven without pins");
  chk_sdo_owned: assert property (!sdoOe_n |-> pinsOwned)
    else $error("data out driven without pins");
  chk_sck_half: assert property (sckMove |=> $stable(sckOut))
    else $error("serial clock half period too short");
endmodule // sync_serial_port_chk
bind sync_serial_port sync_serial_port_chk i_chk (.sys_clk(sys_clk), .nrst(nrst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sckOut(sckOut), .sckOe_n(sckOe_n), .sdoOe_n(sdoOe_n), .pinsOwned(pinsOwned),
  .transferDone(transferDone));
`default_nettype wire

// file: dv/spi_peer_model.sv
// behavioural far-end spi device, slave or master as the bench asks
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input  wire logic sckLine,
  input  wire logic dataIn,
  output var  logic dataOut,
  output var  logic sckDrive,
  output var  logic selectOut_n
);
  logic       pol = 1'b0;
  logic       useSel = 1'b1;
  logic       isMaster = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic [7:0] rxByte = 8'h00;
  int         cnt = 0;
  initial begin
    dataOut = 1'b1;
    sckDrive = 1'b0;
    selectOut_n = 1'b1;
  end
  // ------------------------------------------------------------------
  // slave role: sample on leaving idle, shift out on return to idle;
  // the bench presets the first bit before the frame
  // ------------------------------------------------------------------
  always @(sckLine) begin
    if (!isMaster && sckLine !== pol) begin
      rxByte = {rxByte[6:0], dataIn};
      cnt = cnt + 1;
    end else if (!isMaster) begin
      if (cnt == 8) begin
        cnt = 0;
        dataOut = ~dataOut; // released line must not keep the last bit
      end else begin
        dataOut = txByte[7 - cnt];
      end
    end
  end
  // ------------------------------------------------------------------
  // master role: clock runs only inside the frame
  // ------------------------------------------------------------------
  task automatic run_master(input logic [7:0] tx);
    isMaster = 1'b1;
    #3;
    if (useSel) selectOut_n = 1'b0;
    #80;
    for (int i = 7; i >= 0; i--) begin
      sckDrive = ~pol;
      dataOut = tx[i];
      #80;
      sckDrive = pol;
      rxByte = {rxByte[6:0], dataIn};
      #80;
    end
    selectOut_n = 1'b1;
    dataOut = ~dataOut;
    isMaster = 1'b0;
  endtask
endmodule // spi_peer_model
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module testbench;
  logic        sys_clk = 1'b0, nrst = 1'b0, timerTick = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic        sckOut, sckOe_n, sdo, sdoOe_n, pinsOwned, transferDone, peerData, peerSck, peerSel_n;
  wire logic   sckLine = !sckOe_n ? sckOut : peerSck;
  wire logic   sdoLine = sdoOe_n ? 1'b1 : sdo; // pull-up on the data line
  int          error_cnt = 0, total_checks = 0, tick = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick <= (tick == 9) ? 0 : tick + 1;
    if (tick == 9) timerTick <= ~timerTick;
  end
  sync_serial_port i_sync_serial_port (.sys_clk(sys_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timerTick(timerTick),
    .sckIn(sckLine), .sckOut(sckOut), .sckOe_n(sckOe_n), .sdi(peerData), .sdo(sdo),
    .sdoOe_n(sdoOe_n), .selectIn_n(peerSel_n), .pinsOwned(pinsOwned),
    .transferDone(transferDone));
  spi_peer_model i_spi_peer_model (.sckLine(sckLine), .dataIn(sdoLine), .dataOut(peerData),
    .sckDrive(peerSck), .selectOut_n(peerSel_n));
  // ------------------------------------------------------------------
  // bus tasks and helpers
  // ------------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_wready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_arready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic reg_chk(input logic [3:0] a, input logic [7:0] exp, input string nm);
    axi_rd(a);
    `CHK(nm, {sync_serial_pkg::RESP_OKAY, 24'h0, exp}, {rr, rd})
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (transferDone !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("done pulse", 1'b1, transferDone)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_regs();
    reg_chk(sync_serial_pkg::OFS_STATUS, sync_serial_pkg::STATUS_RST, "status reset");
    reg_chk(sync_serial_pkg::OFS_CONTROL, sync_serial_pkg::CONTROL_RST, "ctrl reset");
    axi_wr(sync_serial_pkg::OFS_STATUS, 8'hFF);
    reg_chk(sync_serial_pkg::OFS_STATUS, 8'hC0, "status writable");
    axi_wr(sync_serial_pkg::OFS_STATUS, 8'h00);
    axi_rd(4'hC);
    `CHK("unmapped", {sync_serial_pkg::RESP_SLVERR, 32'h0}, {rr, rd})
    axi_wr(sync_serial_pkg::OFS_CONTROL, 8'h26);
    `CHK("reserved pins", 1'b0, pinsOwned)
    axi_wr(sync_serial_pkg::OFS_DATA, 8'h11);
    reg_chk(sync_serial_pkg::OFS_CONTROL, 8'hA6, "reserved write");
    $display("test registers done");
  endtask
  task automatic master_xfer(input logic [3:0] md, input logic pol, input logic [7:0] tx,
                             input logic [7:0] px, input int half);
    int n;
    n = 0;
    i_spi_peer_model.pol = pol;
    i_spi_peer_model.txByte = px;
    axi_wr(sync_serial_pkg::OFS_STATUS, 8'h40); // data changes active to idle
    axi_wr(sync_serial_pkg::OFS_CONTROL, {2'b00, 1'b1, pol, md});
    i_spi_peer_model.cnt = 0;
    i_spi_peer_model.dataOut = px[7];
    `CHK("clock idle", pol, sckOut)
    `CHK("clock driven", 1'b0, sckOe_n)
    axi_wr(sync_serial_pkg::OFS_DATA, tx);
    while (sckOut !== pol && n < 9000) begin @(posedge sys_clk); n++; end
    while (sckOut === pol && n < 9000) begin @(posedge sys_clk); n++; end
    n = 0;
    while (sckOut !== pol && n < 9000) begin @(posedge sys_clk); n++; end
    `CHK("half period", half, n)
    axi_wr(sync_serial_pkg::OFS_DATA, 8'hFF); // write mid-transfer must be dropped
    wait_done();
    reg_chk(sync_serial_pkg::OFS_CONTROL, {3'b101, pol, md}, "collision");
    reg_chk(sync_serial_pkg::OFS_STATUS, 8'h41, "full");
    reg_chk(sync_serial_pkg::OFS_DATA, px, "master rx");
    reg_chk(sync_serial_pkg::OFS_STATUS, 8'h40, "emptied");
    `CHK("peer rx", tx, i_spi_peer_model.rxByte)
    `CHK("clock back idle", pol, sckOut)
    $display("test master mode %0h done", md);
  endtask
  task automatic slave_xfer();
    i_spi_peer_model.pol = 1'b0;
    axi_wr(sync_serial_pkg::OFS_STATUS, 8'h00);
    axi_wr(sync_serial_pkg::OFS_CONTROL, 8'h24);
    axi_wr(sync_serial_pkg::OFS_DATA, 8'h5A);
    `CHK("clock input", 1'b1, sckOe_n)
    fork i_spi_peer_model.run_master(8'h96); wait_done(); join
    repeat (4) @(posedge sys_clk);
    `CHK("select release", 1'b1, sdoOe_n)
    `CHK("slave tx", 8'h5A, i_spi_peer_model.rxByte)
    i_spi_peer_model.run_master(8'h33);
    reg_chk(sync_serial_pkg::OFS_DATA, 8'h96, "kept word");
    reg_chk(sync_serial_pkg::OFS_CONTROL, 8'h64, "overflow");
    i_spi_peer_model.useSel = 1'b0;
    axi_wr(sync_serial_pkg::OFS_CONTROL, 8'h25);
    axi_wr(sync_serial_pkg::OFS_DATA, 8'hC3);
    fork i_spi_peer_model.run_master(8'h0F); wait_done(); join
    reg_chk(sync_serial_pkg::OFS_DATA, 8'h0F, "free select rx");
    `CHK("free select tx", 8'hC3, i_spi_peer_model.rxByte)
    axi_wr(sync_serial_pkg::OFS_CONTROL, 8'h00);
    `CHK("pins freed", 1'b0, pinsOwned)
    reg_chk(sync_serial_pkg::OFS_STATUS, 8'h00, "stop flag");
    $display("test slave done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    test_regs();
    master_xfer(sync_serial_pkg::MODE_DIV4, 1'b0, 8'hA5, 8'h3C, 2);
    master_xfer(sync_serial_pkg::MODE_DIV16, 1'b0, 8'h81, 8'h7E, 8);
    master_xfer(sync_serial_pkg::MODE_DIV64, 1'b0, 8'h01, 8'h80, 32);
    master_xfer(sync_serial_pkg::MODE_TIMER, 1'b1, 8'hC6, 8'h5B, 20);
    slave_xfer();
    give_verdict();
  end
  initial begin
    #300000;
    error_cnt++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
